// *** hdl/fccio_pkg.sv ***
package fccio_pkg;

  // ---------------------------------------------------------------
  // register word offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_IOCTL_AB = 5'h00;
  localparam logic [4:0] OFF_IOCTL_CD = 5'h04;
  localparam logic [4:0] OFF_COUNTER = 5'h08;
  localparam logic [4:0] OFF_GENREG_A = 5'h0c;
  localparam logic [4:0] OFF_GENREG_B = 5'h10;
  localparam logic [4:0] OFF_GENREG_C = 5'h14;
  localparam logic [4:0] OFF_GENREG_D = 5'h18;
  localparam logic [4:0] OFF_CONTROL = 5'h1c;

  // ---------------------------------------------------------------
  // status / enable word layout (status word at 0x20, enable word at 0x24)
  // ---------------------------------------------------------------
  localparam logic [5:0] OFF_STATUS = 6'h20;
  localparam logic [5:0] OFF_IRQ_EN = 6'h24;
  localparam int STAT_OVF_BIT = 7;
  localparam int STAT_RSV_MASK_LO = 4;
  localparam logic [7:0] STAT_RSV_ONES = 8'h70;
  localparam int IRQEN_OVF_BIT = 7;

  // ---------------------------------------------------------------
  // i/o control field layout (high nibble: b/d, low nibble: a/c)
  // ---------------------------------------------------------------
  localparam int IOCTL_ROLE_HI = 6;
  localparam int IOCTL_ROLE_LO = 2;
  localparam int IOCTL_ACT_HI = 4;
  localparam int IOCTL_ACT_LO = 0;
  localparam logic [7:0] IOCTL_RSV_ONES = 8'h88;
  localparam logic [7:0] IOCTL_WR_MASK = 8'h77;
  localparam logic [7:0] IOCTL_RESET = 8'h88;

  // ---------------------------------------------------------------
  // timer control layout
  // ---------------------------------------------------------------
  localparam int CTRL_CLR_BIT = 7;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_CKS_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] GENREG_RESET = 16'hffff;
  localparam logic [15:0] COUNTER_MAX = 16'hffff;

  // ---------------------------------------------------------------
  // channel pin action codes and clock selects
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } fccio_act_t;

  localparam logic [2:0] CKS_EXT = 3'h7;

  // per-channel configuration carried together
  typedef struct packed {
    logic capture;
    logic [1:0] action;
  } fccio_chcfg_t;

endpackage

// *** hdl/fccio_timer.sv ***
`timescale 1ns/10ps
// Operation
// - reserved bits 7,3 read one, ignore writes
// - ab bit 6 sets channel b role
// - ab bit 2 sets channel a role
// - cd bit 6 sets channel d role
// - cd bit 2 sets channel c role
// - compare action 00 leaves pin alone
// - compare action 01 drives pin low
// - compare action 10 drives pin high
// - compare action 11 toggles the pin
// - capture action 00 on rising edge
// - capture action 01 on falling edge
// - capture action 1x on both edges
// - sixteen bit counter, software readable and writable
// - three bit clock select picks count rate
// - clear-on-match zeroes counter at channel a
// - counter wrap sets overflow flag
// - overflow interrupt only when enabled
// - counter resets to zero
// - match or capture sets channel flag, irq only when enabled
// - general registers reset to all ones
// - match acts at next counter clock
module fccio_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // channel pins a..d (bit 0 = a)
  input wire logic [3:0] pinChanIn,
  output logic [3:0] pinChanOut,
  output logic [3:0] pinChanOe,
  // external count clock
  input wire logic extCountClk,
  // interrupt requests
  output logic irqOverflow,
  output logic [3:0] irqChan
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ioControlChanAb;
  logic [7:0] ioControlChanCd;
  logic [15:0] upCounter;
  logic [15:0] generalReg [4];
  logic [7:0] timerControlReg;
  logic [7:0] timerIrqEnableReg;
  logic overflowFlag;
  logic [3:0] matchCaptureFlag;
  logic [4:0] flagSeenOne;
  logic ackPhase;
  logic [2:0] divCount;
  logic [1:0] extSample;
  logic [3:0] pinSync1;
  logic [3:0] pinSync2;
  logic [3:0] pinPrev;
  logic countTick;
  logic [3:0] matchNow;
  logic [3:0] matchEvent;
  logic [3:0] captureEvent;
  logic clearOnMatch;
  logic wrAccept;
  logic rdAccept;
  logic [15:0] next_upCounter;
  fccio_pkg::fccio_chcfg_t chCfg [4];

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic fccio_pkg::fccio_chcfg_t cfgOf(input logic [7:0] ctl, input logic hi);
    fccio_pkg::fccio_chcfg_t c;
    if (hi) begin
      c.capture = ctl[fccio_pkg::IOCTL_ROLE_HI];
      c.action = ctl[fccio_pkg::IOCTL_ACT_HI +: 2];
    end else begin
      c.capture = ctl[fccio_pkg::IOCTL_ROLE_LO];
      c.action = ctl[fccio_pkg::IOCTL_ACT_LO +: 2];
    end
    return c;
  endfunction

  always_comb begin
    chCfg[0] = cfgOf(ioControlChanAb, 1'b0);
    chCfg[1] = cfgOf(ioControlChanAb, 1'b1);
    chCfg[2] = cfgOf(ioControlChanCd, 1'b0);
    chCfg[3] = cfgOf(ioControlChanCd, 1'b1);
  end

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait cycle so read data always comes from a flop
  assign avsWaitRequest = (avsRead | avsWrite) & ~ackPhase;
  assign wrAccept = avsWrite & ackPhase;
  assign rdAccept = avsRead & ackPhase;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ackPhase <= 1'b0;
    end else begin
      ackPhase <= (avsRead | avsWrite) & ~ackPhase;
    end
  end

  // ---------------------------------------------------------------
  // count rate: prescaled system clock or sampled external clock
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      divCount <= 3'h0;
      extSample <= 2'h0;
    end else begin
      divCount <= divCount + 3'h1;
      extSample <= {extSample[0], extCountClk};
    end
  end

  always_comb begin
    unique case (timerControlReg[fccio_pkg::CTRL_CKS_LO +: 3])
      3'h0: countTick = 1'b1;
      3'h1: countTick = (divCount[0] == 1'b1);
      3'h2: countTick = (divCount[1:0] == 2'h3);
      3'h3: countTick = (divCount == 3'h7);
      fccio_pkg::CKS_EXT: countTick = extSample[0] & ~extSample[1];
      default: countTick = 1'b0;
    endcase
    countTick = countTick & timerControlReg[fccio_pkg::CTRL_RUN_BIT];
  end

  // ---------------------------------------------------------------
  // pin sampling and edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pinSync1 <= 4'h0;
      pinSync2 <= 4'h0;
      pinPrev <= 4'h0;
    end else begin
      pinSync1 <= pinChanIn;
      pinSync2 <= pinSync1;
      pinPrev <= pinSync2;
    end
  end

  // ---------------------------------------------------------------
  // compare match and capture per channel
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : gChan
      logic rise;
      logic fall;
      assign rise = pinSync2[ch] & ~pinPrev[ch];
      assign fall = ~pinSync2[ch] & pinPrev[ch];
      assign matchNow[ch] = (upCounter == generalReg[ch]);
      // match only when counter leaves the matching value
      assign matchEvent[ch] = ~chCfg[ch].capture & matchNow[ch] & countTick;
      assign captureEvent[ch] = chCfg[ch].capture & (chCfg[ch].action[1] ? (rise | fall)
                              : chCfg[ch].action[0] ? fall
                              : rise);

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pinChanOut[ch] <= 1'b0;
        end else if (matchEvent[ch]) begin
          unique case (chCfg[ch].action)
            fccio_pkg::ACT_NONE: pinChanOut[ch] <= pinChanOut[ch];
            fccio_pkg::ACT_LOW: pinChanOut[ch] <= 1'b0;
            fccio_pkg::ACT_HIGH: pinChanOut[ch] <= 1'b1;
            fccio_pkg::ACT_TOGGLE: pinChanOut[ch] <= ~pinChanOut[ch];
          endcase
        end
      end

      // capture pins float so the far side may drive them
      assign pinChanOe[ch] = ~chCfg[ch].capture;

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          generalReg[ch] <= fccio_pkg::GENREG_RESET;
        end else if (captureEvent[ch]) begin
          // capture beats a software write in the same cycle
          generalReg[ch] <= upCounter;
        end else if (wrAccept && avsAddress == fccio_pkg::OFF_GENREG_A + 6'(4 * ch)
                     && avsByteEnable[1:0] == 2'h3) begin
          generalReg[ch] <= avsWriteData[15:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // up-counter
  // ---------------------------------------------------------------
  assign clearOnMatch = timerControlReg[fccio_pkg::CTRL_CLR_BIT] & matchEvent[0];

  always_comb begin
    next_upCounter = upCounter;
    if (clearOnMatch) begin
      next_upCounter = fccio_pkg::COUNTER_RESET;
    end else if (countTick) begin
      next_upCounter = upCounter + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upCounter <= fccio_pkg::COUNTER_RESET;
    end else if (wrAccept && avsAddress == 6'(fccio_pkg::OFF_COUNTER)
                 && avsByteEnable[1:0] == 2'h3) begin
      // single-byte writes refused, counter is 16-bit only
      upCounter <= avsWriteData[15:0];
    end else begin
      upCounter <= next_upCounter;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ioControlChanAb <= fccio_pkg::IOCTL_RESET;
      ioControlChanCd <= fccio_pkg::IOCTL_RESET;
      timerControlReg <= fccio_pkg::CTRL_RESET;
      timerIrqEnableReg <= 8'h00;
    end else if (wrAccept && avsByteEnable[0]) begin
      unique case (avsAddress)
        6'(fccio_pkg::OFF_IOCTL_AB): ioControlChanAb <= fccio_pkg::IOCTL_RSV_ONES
            | (avsWriteData[7:0] & fccio_pkg::IOCTL_WR_MASK);
        6'(fccio_pkg::OFF_IOCTL_CD): ioControlChanCd <= fccio_pkg::IOCTL_RSV_ONES
            | (avsWriteData[7:0] & fccio_pkg::IOCTL_WR_MASK);
        6'(fccio_pkg::OFF_CONTROL): timerControlReg <= avsWriteData[7:0];
        fccio_pkg::OFF_IRQ_EN: timerIrqEnableReg <= avsWriteData[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status flags: set wins over clear
  // ---------------------------------------------------------------
  logic statusWrite;
  logic [4:0] flagSet;
  logic [4:0] flagNow;
  logic [4:0] flagClr;
  assign statusWrite = wrAccept & avsByteEnable[0] & (avsAddress == fccio_pkg::OFF_STATUS);
  assign flagSet = {countTick & ~clearOnMatch & (upCounter == fccio_pkg::COUNTER_MAX),
                    matchEvent | captureEvent};
  assign flagNow = {overflowFlag, matchCaptureFlag};
  // a zero write clears only a flag already read as one
  assign flagClr = statusWrite ? (flagSeenOne & ~{avsWriteData[fccio_pkg::STAT_OVF_BIT],
                   avsWriteData[3:0]}) : 5'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overflowFlag <= 1'b0;
      matchCaptureFlag <= 4'h0;
      flagSeenOne <= 5'h00;
    end else begin
      overflowFlag <= flagSet[4] | (flagNow[4] & ~flagClr[4]);
      matchCaptureFlag <= flagSet[3:0] | (flagNow[3:0] & ~flagClr[3:0]);
      if (rdAccept && avsAddress == fccio_pkg::OFF_STATUS) begin
        flagSeenOne <= flagNow;
      end else if (statusWrite) begin
        flagSeenOne <= 5'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqOverflow <= 1'b0;
      irqChan <= 4'h0;
    end else begin
      irqOverflow <= overflowFlag & timerIrqEnableReg[fccio_pkg::IRQEN_OVF_BIT];
      irqChan <= matchCaptureFlag & timerIrqEnableReg[3:0];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avsReadData <= 32'h0000_0000;
    end else if (avsRead && !ackPhase) begin
      unique case (avsAddress)
        6'(fccio_pkg::OFF_IOCTL_AB): avsReadData <= {24'h0, ioControlChanAb};
        6'(fccio_pkg::OFF_IOCTL_CD): avsReadData <= {24'h0, ioControlChanCd};
        6'(fccio_pkg::OFF_COUNTER): avsReadData <= {16'h0, upCounter};
        6'(fccio_pkg::OFF_GENREG_A): avsReadData <= {16'h0, generalReg[0]};
        6'(fccio_pkg::OFF_GENREG_B): avsReadData <= {16'h0, generalReg[1]};
        6'(fccio_pkg::OFF_GENREG_C): avsReadData <= {16'h0, generalReg[2]};
        6'(fccio_pkg::OFF_GENREG_D): avsReadData <= {16'h0, generalReg[3]};
        6'(fccio_pkg::OFF_CONTROL): avsReadData <= {24'h0, timerControlReg};
        fccio_pkg::OFF_STATUS: avsReadData <= {24'h0, overflowFlag, fccio_pkg::STAT_RSV_ONES[6:4],
                                               matchCaptureFlag};
        fccio_pkg::OFF_IRQ_EN: avsReadData <= {24'h0, timerIrqEnableReg};
        default: avsReadData <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// *** bench/fccio_timer_assertions.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// port checker
// ----------------------------------------
module fccio_timer_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  // pins and irq
  input wire logic [3:0] pinChanOut,
  input wire logic [3:0] pinChanOe,
  input wire logic irqOverflow,
  input wire logic [3:0] irqChan
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic rdDone;
  assign req = avsRead || avsWrite;
  assign rdDone = avsRead && !avsWaitRequest;
  wait_first_a: assert property (req && avsWaitRequest |=> !avsWaitRequest)
    else $error("no answer after one wait cycle");
  wait_rearm_a: assert property (req && !avsWaitRequest ##1 req |-> avsWaitRequest)
    else $error("no wait cycle on follow-on request");
  // read data must survive idle and write cycles
  rdata_hold_a: assert property (!(avsRead && avsWaitRequest) |=> $stable(avsReadData))
    else $error("read data moved without a read");
  ioctl_rsv_a: assert property (
    rdDone && (avsAddress == 6'h00 || avsAddress == 6'h04) |-> avsReadData[7] && avsReadData[3])
    else $error("reserved control bits not one");
  unmapped_zero_a: assert property (rdDone && avsAddress > 6'h24 |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  pin_hold_a: assert property (((pinChanOut ^ $past(pinChanOut)) & ~$past(pinChanOe)) == 4'h0)
    else $error("capture pin output moved");
  reset_pins_a: assert property (
    $rose(rst_n) |-> pinChanOut == 4'h0 && pinChanOe == 4'hf && !irqOverflow && irqChan == 4'h0)
    else $error("pin or irq reset value wrong");
  role_write_a: assert property ($changed(pinChanOe) |-> $past(avsWrite && !avsWaitRequest))
    else $error("pin role changed without a write");
endmodule

bind fccio_timer fccio_timer_chk fccio_timer_chk_inst (
  .mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .pinChanOut(pinChanOut), .pinChanOe(pinChanOe), .irqOverflow(irqOverflow),
  .irqChan(irqChan)
);

// *** bench/fccio_pin_model.sv ***
`timescale 1ns/10ps
module fccio_pin_model (
  // design side
  input wire logic [3:0] pinChanOut,
  input wire logic [3:0] pinChanOe,
  // far-end level, seen only while the design listens
  input wire logic [3:0] extLevel,
  // resolved wire
  output logic [3:0] pinChanIn
);
  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  assign pinChanIn = (pinChanOut & pinChanOe) | (extLevel & ~pinChanOe);
endmodule

// *** bench/fccio_timer_tb.sv ***
`timescale 1ns/10ps
module fccio_timer_tb;
  // ----------------------------------------
  // bench state
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] data;
    logic [3:0] be;
    logic [31:0] expd;
  } fccio_row_t;
  logic mclk, rst_n, avsRead, avsWrite, avsWaitRequest, extCountClk, irqOverflow;
  logic [5:0] avsAddress, a;
  logic [31:0] avsWriteData, avsReadData, q;
  logic [3:0] avsByteEnable, pinChanIn, pinChanOut, pinChanOe, irqChan, extLevel;
  int fails, compares;
  fccio_row_t rows [7];
  fccio_pkg::fccio_act_t acts [4];
  logic pinExp [4];

  fccio_timer fccio_timer_inst (.mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .pinChanIn(pinChanIn), .pinChanOut(pinChanOut),
    .pinChanOe(pinChanOe), .extCountClk(extCountClk), .irqOverflow(irqOverflow),
    .irqChan(irqChan));
  fccio_pin_model fccio_pin_model_inst (.pinChanOut(pinChanOut), .pinChanOe(pinChanOe),
    .extLevel(extLevel), .pinChanIn(pinChanIn));

  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge mclk);
    avsAddress <= ad;
    avsWrite <= w;
    avsRead <= ~w;
    avsWriteData <= d;
    avsByteEnable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [5:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0, 4'hf);
    chk(q, exp);
  endtask

  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // sized from the longest sequence with wide margin
  initial begin
    repeat (6000) @(posedge mclk);
    fails++;
    end_of_test();
  end

  initial begin
    {rst_n, avsRead, avsWrite, extCountClk, avsAddress, avsWriteData} = '0;
    {avsByteEnable, extLevel, fails, compares} = '0;
    rows = '{'{6'h00, 32'hff, 4'h1, 32'hff}, '{6'h00, 32'h00, 4'h1, 32'h88},
             '{6'h04, 32'h44, 4'h1, 32'hcc}, '{6'h08, 32'h1234, 4'h3, 32'h1234},
             '{6'h08, 32'h5678, 4'h1, 32'h1234}, '{6'h10, 32'haa, 4'h3, 32'haa},
             '{6'h28, 32'h5a, 4'hf, 32'h0}};
    acts = '{fccio_pkg::ACT_HIGH, fccio_pkg::ACT_NONE, fccio_pkg::ACT_LOW, fccio_pkg::ACT_TOGGLE};
    pinExp = '{1'b1, 1'b1, 1'b0, 1'b1};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].data, rows[i].be);
      rdchk(rows[i].addr, rows[i].expd);
    end
    $display("register rows done");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(6'h08, 32'h0);
    for (a = 6'h0c; a < 6'h1c; a = a + 6'h04) rdchk(a, 32'hffff);
    rdchk(6'h04, 32'h88);
    chk({28'h0, pinChanOe}, 32'hf);
    $display("reset done");
    bus(1'b1, 6'h24, 32'h01, 4'h1);
    foreach (acts[k]) begin
      bus(1'b1, 6'h1c, 32'h0, 4'h1);
      bus(1'b1, 6'h08, 32'h0, 4'h3);
      bus(1'b1, 6'h0c, 32'h5, 4'h3);
      bus(1'b1, 6'h00, {30'h0, acts[k]}, 4'h1);
      bus(1'b1, 6'h1c, 32'h08, 4'h1);
      repeat (20) @(posedge mclk);
      chk({31'h0, pinChanOut[0]}, {31'h0, pinExp[k]});
      chk({31'h0, irqChan[0]}, 32'h1);
      rdchk(6'h20, 32'h71);
      bus(1'b1, 6'h20, 32'h0, 4'h1);
      rdchk(6'h20, 32'h70);
    end
    $display("compare actions done");
    bus(1'b1, 6'h1c, 32'h0, 4'h1);
    bus(1'b1, 6'h08, 32'h0, 4'h3);
    bus(1'b1, 6'h0c, 32'h3, 4'h3);
    bus(1'b1, 6'h1c, 32'h88, 4'h1);
    repeat (30) @(posedge mclk);
    bus(1'b0, 6'h08, 32'h0, 4'hf);
    chk({31'h0, q[15:0] < 16'h4}, 32'h1);
    bus(1'b1, 6'h1c, 32'h0, 4'h1);
    bus(1'b1, 6'h24, 32'h80, 4'h1);
    bus(1'b1, 6'h08, 32'hfffd, 4'h3);
    bus(1'b1, 6'h1c, 32'h08, 4'h1);
    repeat (10) @(posedge mclk);
    chk({31'h0, irqOverflow}, 32'h1);
    bus(1'b0, 6'h20, 32'h0, 4'hf);
    chk({31'h0, q[7]}, 32'h1);
    bus(1'b1, 6'h24, 32'h0, 4'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irqOverflow}, 32'h0);
    $display("counter done");
    bus(1'b1, 6'h1c, 32'h0, 4'h1);
    bus(1'b1, 6'h08, 32'h0123, 4'h3);
    bus(1'b1, 6'h00, 32'h54, 4'h1);
    // let the pins settle low after the role change, no false edge
    repeat (6) @(posedge mclk);
    extLevel <= 4'h3;
    repeat (6) @(posedge mclk);
    rdchk(6'h0c, 32'h0123);
    rdchk(6'h10, 32'hffff);
    bus(1'b1, 6'h08, 32'h0456, 4'h3);
    extLevel <= 4'h0;
    repeat (6) @(posedge mclk);
    rdchk(6'h0c, 32'h0123);
    rdchk(6'h10, 32'h0456);
    bus(1'b1, 6'h04, 32'h66, 4'h1);
    bus(1'b1, 6'h08, 32'h0789, 4'h3);
    extLevel <= 4'hc;
    repeat (6) @(posedge mclk);
    rdchk(6'h14, 32'h0789);
    rdchk(6'h18, 32'h0789);
    bus(1'b1, 6'h08, 32'h0abc, 4'h3);
    extLevel <= 4'h0;
    repeat (6) @(posedge mclk);
    rdchk(6'h14, 32'h0abc);
    rdchk(6'h18, 32'h0abc);
    chk({28'h0, pinChanOe}, 32'h0);
    $display("capture done");
    bus(1'b1, 6'h08, 32'h0, 4'h3);
    bus(1'b1, 6'h1c, 32'h0f, 4'h1);
    repeat (3) begin
      extCountClk <= 1'b1;
      repeat (2) @(posedge mclk);
      extCountClk <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    rdchk(6'h08, 32'h3);
    $display("external clock done");
    end_of_test();
  end
endmodule
